/* design/idosc_top.sv */
// debounce time and output stage mode/power control registers
`timescale 1ns/100ps
module idosc_top
(
    input  wire logic                    SYS_CLK_I,
    input  wire logic                    NRST_I,
    input  wire logic                    WR_EN_I,
    input  wire logic [7:0]              ADDR_I,
    input  wire logic [7:0]              WDATA_I,
    output logic      [7:0]              RDATA_O,
    input  wire logic [idosc_pkg::NUM_PINS-1:0] MULTIPURPOSE_PIN_I,
    output logic      [idosc_pkg::NUM_PINS-1:0] MULTIPURPOSE_PIN_O,
    output logic                         RIGHT_PHONES_MODE_SEL_O,
    output logic                         LEFT_PHONES_MODE_SEL_O,
    output logic                         RIGHT_NEGATIVE_LEG_EN_O,
    output logic                         RIGHT_POSITIVE_LEG_EN_O,
    output logic                         LEFT_NEGATIVE_LEG_EN_O,
    output logic                         LEFT_POSITIVE_LEG_EN_O
);
    import idosc_pkg::*;

    logic [7:0] input_debounce_time;
    logic [7:0] output_stage_mode_power;
    logic [7:0] next_rdata;

    // one decode serves both channels: field bit 1 cuts negative, bit 0 cuts positive
    function automatic logic [1:0] leg_enables(input logic [1:0] field);
        leg_enables = ~field;
    endfunction

    wire wr_deb = WR_EN_I && (ADDR_I == ADDR_DEBOUNCE);
    wire wr_out = WR_EN_I && (ADDR_I == ADDR_OUTSTAGE);
    wire [2:0] deb_sel = input_debounce_time[DEB_SEL_LSB +: 3];
    wire [1:0] right_out_power_ctl = output_stage_mode_power[RIGHT_PWR_LSB +: 2];
    wire [1:0] left_out_power_ctl  = output_stage_mode_power[LEFT_PWR_LSB +: 2];
    wire [1:0] next_right_legs = leg_enables(right_out_power_ctl); // [RULE_04] [RULE_06]
    wire [1:0] next_left_legs  = leg_enables(left_out_power_ctl);  // [RULE_05] [RULE_06]
    wire       rd_unmapped = (ADDR_I != ADDR_DEBOUNCE) && (ADDR_I != ADDR_OUTSTAGE);

    // unmapped addresses read zero
    assign next_rdata = (ADDR_I == ADDR_DEBOUNCE) ? input_debounce_time :
                        (ADDR_I == ADDR_OUTSTAGE) ? output_stage_mode_power : 8'h00;

    // full byte stored, reserved bits included and never decoded
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            input_debounce_time     <= RST_DEBOUNCE; // [RULE_01] [RULE_10]
            output_stage_mode_power <= RST_OUTSTAGE; // [RULE_08] [RULE_10]
        end else begin
            if (wr_deb) begin
                input_debounce_time <= WDATA_I; // [RULE_10]
            end
            if (wr_out) begin
                output_stage_mode_power <= WDATA_I; // [RULE_10]
            end
        end
    end

    // registered read costs a cycle of latency but keeps RDATA_O off the address decode
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= next_rdata;
        end
    end

    // leg enables decode only the power fields, so mode never wakes a stage
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            RIGHT_PHONES_MODE_SEL_O <= 1'b0;
            LEFT_PHONES_MODE_SEL_O  <= 1'b0;
            RIGHT_NEGATIVE_LEG_EN_O <= 1'b0;
            RIGHT_POSITIVE_LEG_EN_O <= 1'b0;
            LEFT_NEGATIVE_LEG_EN_O  <= 1'b0;
            LEFT_POSITIVE_LEG_EN_O  <= 1'b0;
        end else begin
            RIGHT_PHONES_MODE_SEL_O <= output_stage_mode_power[RIGHT_MODE_BIT]; // [RULE_02]
            LEFT_PHONES_MODE_SEL_O  <= output_stage_mode_power[LEFT_MODE_BIT];  // [RULE_03]
            RIGHT_NEGATIVE_LEG_EN_O <= next_right_legs[1]; // [RULE_04] [RULE_06]
            RIGHT_POSITIVE_LEG_EN_O <= next_right_legs[0]; // [RULE_04] [RULE_06]
            LEFT_NEGATIVE_LEG_EN_O  <= next_left_legs[1];  // [RULE_05] [RULE_06]
            LEFT_POSITIVE_LEG_EN_O  <= next_left_legs[0];  // [RULE_05] [RULE_06]
        end
    end

    // host paces the 6 ms unmute wait; nothing here enforces it [RULE_07]

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : gen_deb
            idosc_debounce u_deb (
                .clk_i   (SYS_CLK_I),
                .nrst_i  (NRST_I),
                .sel_i   (deb_sel),
                .pin_i   (MULTIPURPOSE_PIN_I[g]),
                .level_o (MULTIPURPOSE_PIN_O[g])
            );
        end
    endgenerate

    // reset release, a write and a write followed by a read of the same register
    sequence reset_rel_s;
        !NRST_I ##1 NRST_I;
    endsequence

    sequence out_write_s;
        wr_out ##1 !wr_out;
    endsequence

    sequence deb_write_read_s;
        wr_deb ##1 (ADDR_I == ADDR_DEBOUNCE && !WR_EN_I);
    endsequence

    sequence out_write_read_s;
        wr_out ##1 (ADDR_I == ADDR_OUTSTAGE && !WR_EN_I);
    endsequence

    reset_values_a: assert property (@(posedge SYS_CLK_I) // [RULE_01] [RULE_08] [RULE_10]
        reset_rel_s |-> input_debounce_time == RST_DEBOUNCE
            && output_stage_mode_power == RST_OUTSTAGE)
        else $error("register reset values wrong");

    reset_legs_a: assert property (@(posedge SYS_CLK_I) // [RULE_08]
        reset_rel_s ##1 !wr_out |-> !RIGHT_NEGATIVE_LEG_EN_O && !RIGHT_POSITIVE_LEG_EN_O
            && !LEFT_NEGATIVE_LEG_EN_O && !LEFT_POSITIVE_LEG_EN_O
            && !RIGHT_PHONES_MODE_SEL_O && !LEFT_PHONES_MODE_SEL_O)
        else $error("legs powered after reset");

    // outputs sit at their reset levels for as long as reset is held
    reset_hold_a: assert property (@(posedge SYS_CLK_I) // [RULE_08]
        !NRST_I |=> RDATA_O == 8'h00 && MULTIPURPOSE_PIN_O == '0
            && !RIGHT_PHONES_MODE_SEL_O && !LEFT_PHONES_MODE_SEL_O
            && !RIGHT_NEGATIVE_LEG_EN_O && !RIGHT_POSITIVE_LEG_EN_O
            && !LEFT_NEGATIVE_LEG_EN_O && !LEFT_POSITIVE_LEG_EN_O)
        else $error("outputs not at reset level");

    // control outputs follow a write two edges later
    right_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_02]
        out_write_s |=> RIGHT_PHONES_MODE_SEL_O == $past(WDATA_I[5], 2))
        else $error("right mode mismatch");

    left_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_03]
        out_write_s |=> LEFT_PHONES_MODE_SEL_O == $past(WDATA_I[4], 2))
        else $error("left mode mismatch");

    right_power_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_04]
        out_write_s |=> {RIGHT_NEGATIVE_LEG_EN_O, RIGHT_POSITIVE_LEG_EN_O}
            == ~$past(WDATA_I[3:2], 2))
        else $error("right leg power mismatch");

    left_power_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_05]
        out_write_s |=> {LEFT_NEGATIVE_LEG_EN_O, LEFT_POSITIVE_LEG_EN_O}
            == ~$past(WDATA_I[1:0], 2))
        else $error("left leg power mismatch");

    mode_indep_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_06]
        (right_out_power_ctl == 2'h3) ##1 (right_out_power_ctl == 2'h3)
            |-> !RIGHT_NEGATIVE_LEG_EN_O && !RIGHT_POSITIVE_LEG_EN_O)
        else $error("stage on while powered down");

    left_indep_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_06]
        (left_out_power_ctl == 2'h3) ##1 (left_out_power_ctl == 2'h3)
            |-> !LEFT_NEGATIVE_LEG_EN_O && !LEFT_POSITIVE_LEG_EN_O)
        else $error("left stage on while powered down");

    // readback of whole bytes, reserved bits included
    reserved_rb_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_10]
        deb_write_read_s |=> RDATA_O == $past(WDATA_I, 2))
        else $error("debounce register readback wrong");

    out_rb_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_10]
        out_write_read_s |=> RDATA_O == $past(WDATA_I, 2))
        else $error("output stage register readback wrong");

    unmapped_rd_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_10]
        rd_unmapped |=> RDATA_O == 8'h00)
        else $error("unmapped address read nonzero");

    wr_other_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_01] [RULE_08]
        WR_EN_I && rd_unmapped |=> $stable(input_debounce_time)
            && $stable(output_stage_mode_power))
        else $error("write to other address changed a register");

    deb_sel_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_01]
        wr_deb |=> deb_sel == $past(WDATA_I[2:0]))
        else $error("debounce selector not stored");

    deb_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_01]
        !wr_deb |=> $stable(input_debounce_time))
        else $error("debounce register changed without write");

    out_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_08]
        !wr_out |=> $stable(output_stage_mode_power))
        else $error("output stage register changed without write");

    // pin path seen from the top
    pin_bypass_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_01]
        (deb_sel == DEB_BYPASS) |=> MULTIPURPOSE_PIN_O == $past(MULTIPURPOSE_PIN_I))
        else $error("bypass code did not pass pins through");

    pin_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // [RULE_09]
        (MULTIPURPOSE_PIN_I == MULTIPURPOSE_PIN_O) |=> $stable(MULTIPURPOSE_PIN_O))
        else $error("pin output moved without an input change");
endmodule

/* pkg/idosc_pkg.sv */
// constants and a cycle-count function for the debounce and output stage control registers
// Function
// RULE_01 - three-bit debounce selector, reset 5; codes 0-6 set intervals, 7 bypasses.
// RULE_02 - bit 5 puts right channel in line mode (0) or headphone mode (1).
// RULE_03 - bit 4 puts left channel in line mode (0) or headphone mode (1).
// RULE_04 - right power field: 00 both legs, 01 negative, 10 positive, 11 off.
// RULE_05 - left power field: 00 both legs, 01 negative, 10 positive, 11 off.
// RULE_06 - leg power follows the power field alone, whatever the output mode.
// RULE_07 - host waits at least 6 ms after headphone enable before unmuting.
// RULE_08 - output stage register resets to 0x0F: line mode, all legs off.
// RULE_09 - input change passes only after staying stable for the selected interval.
// RULE_10 - reserved bits reset to zero, read back as written, steer nothing.
package idosc_pkg;
    localparam int          CLK_MHZ         = 125;
    localparam logic [7:0]  ADDR_DEBOUNCE   = 8'h41;
    localparam logic [7:0]  ADDR_OUTSTAGE   = 8'h43;
    localparam logic [7:0]  RST_DEBOUNCE    = 8'h05;
    localparam logic [7:0]  RST_OUTSTAGE    = 8'h0F;
    localparam int          DEB_SEL_LSB     = 0;
    localparam int          RIGHT_MODE_BIT  = 5;
    localparam int          LEFT_MODE_BIT   = 4;
    localparam int          RIGHT_PWR_LSB   = 2;
    localparam int          LEFT_PWR_LSB    = 0;
    localparam logic [2:0]  DEB_BYPASS      = 3'h7;
    localparam int          NUM_PINS        = 7;
    // debounce intervals in microseconds
    localparam int          DEB_US [0:6]    = '{300, 600, 900, 5000, 10000, 20000, 40000};
    localparam int          WAIT_UNMUTE_US  = 6000;
    localparam int          CNT_W           = 23;
    function automatic logic [CNT_W-1:0] deb_cycles(input logic [2:0] sel);
        deb_cycles = CNT_W'(DEB_US[(sel == DEB_BYPASS) ? 0 : sel] * CLK_MHZ);
    endfunction
endpackage

/* design/idosc_debounce.sv */
// one-pin debouncer with selectable stability interval
`timescale 1ns/100ps
module idosc_debounce
    import idosc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic [2:0]       sel_i,
    input  wire logic             pin_i,
    output logic                  level_o
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_level;
    wire              bypass = (sel_i == DEB_BYPASS);
    wire              differs = (pin_i != level_o);
    wire [CNT_W-1:0]  target = deb_cycles(sel_i);
    wire              done = (cnt >= target - CNT_W'(1));

    // counter restarts on any glitch back to the held level
    assign next_cnt   = (!differs || bypass || done) ? '0 : cnt + CNT_W'(1); // [RULE_09]
    assign next_level = (bypass || (differs && done)) ? pin_i : level_o;     // [RULE_01] [RULE_09]

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt     <= '0;
            level_o <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            level_o <= next_level;
        end
    end

    stable_pass_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_09]
        (level_o != $past(level_o)) && !$past(bypass)
            |-> $past(cnt) == $past(target) - CNT_W'(1))
        else $error("level changed before interval elapsed");
    bypass_pass_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE_01]
        bypass ##1 (sel_i == DEB_BYPASS) |-> level_o == $past(pin_i))
        else $error("bypass did not pass input directly");
endmodule

/* tb/idosc_host.sv */
// host model driving the register port on the falling edge
`timescale 1ns/100ps
module idosc_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_en_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // no silence register here, so no unmute is ever issued
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~d;
    endtask
    // registered read: settled one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule

/* tb/idosc_top_tb.sv */
// self-checking bench for the debounce and output stage registers
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module idosc_top_tb;
    import idosc_pkg::*;
    logic       clk, nrst, wr_en, rm, lm, rn, rp, ln, lp;
    logic [7:0] addr, wdata, rdata, v;
    logic [6:0] pin_i, pin_o;
    int         err_count, num_checks, n;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    idosc_host idosc_host_inst (.clk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en),
        .addr_o(addr), .wdata_o(wdata));
    idosc_top idosc_top_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .WR_EN_I(wr_en),
        .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .MULTIPURPOSE_PIN_I(pin_i),
        .MULTIPURPOSE_PIN_O(pin_o), .RIGHT_PHONES_MODE_SEL_O(rm),
        .LEFT_PHONES_MODE_SEL_O(lm), .RIGHT_NEGATIVE_LEG_EN_O(rn),
        .RIGHT_POSITIVE_LEG_EN_O(rp), .LEFT_NEGATIVE_LEG_EN_O(ln),
        .LEFT_POSITIVE_LEG_EN_O(lp));
    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        pin_i = 7'h00;
        err_count = 0;
        num_checks = 0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        idosc_host_inst.rd(ADDR_DEBOUNCE, v);
        `CHK("debounce_reset", RST_DEBOUNCE, v)
        idosc_host_inst.rd(ADDR_OUTSTAGE, v);
        `CHK("outstage_reset", RST_OUTSTAGE, v)
        `CHK("outputs_reset", 6'h00, {rm, lm, rn, rp, ln, lp})
        // every code, reserved bits included, both modes with every power field
        for (int i = 0; i < 256; i++) begin
            idosc_host_inst.wr(ADDR_OUTSTAGE, i[7:0]);
            @(negedge clk);
            `CHK("modes", {i[5], i[4]}, {rm, lm})
            `CHK("right_legs", ~i[3:2], {rn, rp})
            `CHK("left_legs", ~i[1:0], {ln, lp})
            idosc_host_inst.rd(ADDR_OUTSTAGE, v);
            `CHK("outstage_rw", i[7:0], v)
        end
        // reset in mid-run must restore defaults over the last written code
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        idosc_host_inst.rd(ADDR_OUTSTAGE, v);
        `CHK("outstage_rerst", RST_OUTSTAGE, v)
        `CHK("outputs_rerst", 6'h00, {rm, lm, rn, rp, ln, lp})
        idosc_host_inst.wr(8'h42, 8'h5A);
        idosc_host_inst.rd(8'h42, v);
        `CHK("unmapped", 8'h00, v)
        idosc_host_inst.rd(ADDR_DEBOUNCE, v);
        `CHK("debounce_kept", RST_DEBOUNCE, v)
        idosc_host_inst.wr(ADDR_DEBOUNCE, 8'hFF);
        idosc_host_inst.rd(ADDR_DEBOUNCE, v);
        `CHK("debounce_rw", 8'hFF, v)
        pin_i = 7'h55;
        @(negedge clk);
        `CHK("bypass", 7'h55, pin_o)
        idosc_host_inst.wr(ADDR_DEBOUNCE, 8'h00);
        // glitch must restart the stability count
        pin_i = 7'h2A;
        repeat (1000) @(negedge clk);
        pin_i = 7'h55;
        repeat (10) @(negedge clk);
        pin_i = 7'h2A;
        repeat (37000) @(negedge clk);
        `CHK("held_off", 7'h55, pin_o)
        n = 0;
        while (pin_o !== 7'h2A && n < 1000) begin
            @(negedge clk);
            n++;
        end
        `CHK("debounced", 7'h2A, pin_o)
        // code 1 must still hold off where code 0 would already have passed
        idosc_host_inst.wr(ADDR_DEBOUNCE, 8'h01);
        pin_i = 7'h55;
        repeat (38000) @(negedge clk);
        `CHK("longer_hold", 7'h2A, pin_o)
        report_and_stop();
    end
endmodule
